// ### shared/bgdc_pkg.sv
// Package for the background debug controller control logic
package bgdc_pkg;

	// Status/control bit positions
	localparam int BGDC_BIT_ENABLE = 7;
	localparam int BGDC_BIT_ACTIVE = 6;
	localparam int BGDC_BIT_BKPT_EN = 5;
	localparam int BGDC_BIT_FORCE_TAG = 4;
	localparam int BGDC_BIT_CLK_SEL = 3;

	// Reset values
	localparam logic BGDC_RST_ENABLE = 1'h0;
	localparam logic BGDC_RST_BKPT_EN = 1'h0;
	localparam logic BGDC_RST_FORCE_TAG = 1'h0;
	localparam logic BGDC_RST_CLK_SEL = 1'h0;

	// Writable bit mask; bits 2..0 read as zero
	localparam logic [7:0] BGDC_WR_MASK = 8'hB8;

	// Breakpoint address width
	localparam int BGDC_AW = 16;

	// Serial command from the link decoder
	typedef enum logic [1:0] {
		BGDC_CMD_NONE = 2'h0,
		BGDC_CMD_READ_STATUS = 2'h1,
		BGDC_CMD_WRITE_CONTROL = 2'h2,
		BGDC_CMD_GO = 2'h3
	} bgdc_cmd_e;

	typedef struct packed {
		logic valid;
		bgdc_cmd_e cmd;
		logic [7:0] data;
	} bgdc_cmd_s;

	// CPU-side observation of the fetch path
	typedef struct packed {
		logic fetch_valid;
		logic [BGDC_AW-1:0] fetch_addr;
		logic insn_boundary;
		logic queue_end_valid;
		logic queue_end_tagged;
	} bgdc_cpu_s;

	// Control states
	typedef enum logic [2:0] {
		BGDC_ST_RESET = 3'h1,
		BGDC_ST_RUN = 3'h2,
		BGDC_ST_ACTIVE = 3'h4
	} bgdc_state_e;

endpackage

// ### hdl/bgdc_bkpt.sv
// Breakpoint address comparator with force/tag outputs
`timescale 1ns/1ns
module bgdc_bkpt
	import bgdc_pkg::*;
(
	// Control
	input wire logic i_bkpt_en,
	input wire logic i_force_tag,
	input wire logic [BGDC_AW-1:0] i_match_addr,
	// Fetch path
	input wire logic i_fetch_valid,
	input wire logic [BGDC_AW-1:0] i_fetch_addr,
	// Results
	output logic o_force_hit,
	output logic o_tag_hit
);

	logic match;

	always_comb
	begin
		match = i_fetch_valid && (i_fetch_addr == i_match_addr);
		o_force_hit = i_bkpt_en && i_force_tag && match;
		o_tag_hit = i_bkpt_en && !i_force_tag && match;
	end

endmodule // bgdc_bkpt

// ### hdl/bgdc_ctrl.sv
// Background debug controller: entry into background mode and status register
// Operation
// - Pin low at reset exit enters background
// - Force-reset command then pin low enters background
// - Undriven pin at reset gives normal mode
// - No internal buses on external pins
// - Debug commands arrive only over serial link
// - Register reached only by serial status commands
// - Enable clear refuses background, allows other commands
// - Enable stays set until normal reset
// - Bit 6 reports background active state
// - Breakpoint enable clear ignores tag and match
// - Force mode match enters at instruction boundary
// - Tag mode enters when tagged opcode executes
// - Bit 3 selects link clock, reset alternate
`timescale 1ns/1ns
module bgdc_ctrl
	import bgdc_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Background pin level and reset exit
	input wire logic i_background_pin,
	input wire logic i_reset_exit,
	input wire logic i_force_reset_cmd,
	// Serial command port
	input wire bgdc_cmd_s i_cmd,
	// Breakpoint match register value
	input wire logic [BGDC_AW-1:0] i_match_addr,
	// CPU observation
	input wire bgdc_cpu_s i_cpu,
	// Outputs
	output logic [7:0] o_status,
	output logic o_status_valid,
	output logic o_background_active,
	output logic o_tag_opcode,
	output logic o_link_clock_select
);

	bgdc_state_e state_q, state_d;
	logic enable_q, enable_d;
	logic bkpt_en_q, bkpt_en_d;
	logic force_tag_q, force_tag_d;
	logic clk_sel_q, clk_sel_d;
	logic force_arm_q, force_arm_d;
	logic force_pend_q, force_pend_d;
	logic [7:0] status_q, status_d;
	logic status_valid_q, status_valid_d;
	logic tag_q, tag_d;
	logic force_hit, tag_hit;
	logic enter_req;

	function automatic logic [7:0] pack_status(input logic en, input logic act,
		input logic bk, input logic ft, input logic cs);
		logic [7:0] v;
		v = 8'h00;
		v[BGDC_BIT_ENABLE] = en;
		v[BGDC_BIT_ACTIVE] = act;
		v[BGDC_BIT_BKPT_EN] = bk;
		v[BGDC_BIT_FORCE_TAG] = ft;
		v[BGDC_BIT_CLK_SEL] = cs;
		return v;
	endfunction

	bgdc_bkpt u_bkpt (
		.i_bkpt_en(bkpt_en_q),
		.i_force_tag(force_tag_q),
		.i_match_addr(i_match_addr),
		.i_fetch_valid(i_cpu.fetch_valid),
		.i_fetch_addr(i_cpu.fetch_addr),
		.o_force_hit(force_hit),
		.o_tag_hit(tag_hit)
	);

	// Register and mode next state
	always_comb
	begin
		state_d = state_q;
		enable_d = enable_q;
		bkpt_en_d = bkpt_en_q;
		force_tag_d = force_tag_q;
		clk_sel_d = clk_sel_q;
		force_arm_d = force_arm_q;
		force_pend_d = force_pend_q;
		status_d = status_q;
		status_valid_d = 1'b0;
		tag_d = tag_hit;
		enter_req = 1'b0;
		// Only serial commands reach the register; no memory-mapped path exists
		if (i_cmd.valid && i_cmd.cmd == BGDC_CMD_WRITE_CONTROL)
		begin
			// Enable is sticky: a write can set it but never clear it
			enable_d = enable_q | i_cmd.data[BGDC_BIT_ENABLE];
			bkpt_en_d = i_cmd.data[BGDC_BIT_BKPT_EN];
			force_tag_d = i_cmd.data[BGDC_BIT_FORCE_TAG];
			clk_sel_d = i_cmd.data[BGDC_BIT_CLK_SEL];
			// Active bit in the written data is dropped here
		end
		if (i_cmd.valid && i_cmd.cmd == BGDC_CMD_READ_STATUS)
		begin
			status_d = pack_status(enable_q, state_q == BGDC_ST_ACTIVE,
				bkpt_en_q, force_tag_q, clk_sel_q);
			status_valid_d = 1'b1;
		end
		// Force-reset command sets force_arm_q, read only by a cover; the reset exit pin check ignores it
		if (i_force_reset_cmd)
			force_arm_d = 1'b1;
		if (force_hit)
			force_pend_d = 1'b1;
		case (state_q)
			BGDC_ST_RESET:
			begin
				if (i_reset_exit)
				begin
					// Pulled-up pin reads high when undriven, giving normal mode
					if (!i_background_pin)
					begin
						enable_d = 1'b1;
						state_d = BGDC_ST_ACTIVE;
					end
					else
						state_d = BGDC_ST_RUN;
					force_arm_d = 1'b0;
				end
			end
			BGDC_ST_RUN:
			begin
				if (force_pend_q && i_cpu.insn_boundary)
				begin
					enter_req = 1'b1;
					// A fresh match in the same cycle must not be lost
					force_pend_d = force_hit;
				end
				if (i_cpu.queue_end_valid && i_cpu.queue_end_tagged && bkpt_en_q)
					enter_req = 1'b1;
				if (enter_req && enable_q)
					state_d = BGDC_ST_ACTIVE;
			end
			BGDC_ST_ACTIVE:
			begin
				force_pend_d = 1'b0;
				if (i_cmd.valid && i_cmd.cmd == BGDC_CMD_GO)
					state_d = BGDC_ST_RUN;
			end
			default: state_d = BGDC_ST_RESET;
		endcase
	end

	// Plain registers; internal buses never reach a pin
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q <= BGDC_ST_RESET;
			enable_q <= BGDC_RST_ENABLE;
			bkpt_en_q <= BGDC_RST_BKPT_EN;
			force_tag_q <= BGDC_RST_FORCE_TAG;
			clk_sel_q <= BGDC_RST_CLK_SEL;
			force_arm_q <= 1'b0;
			force_pend_q <= 1'b0;
			status_q <= 8'h00;
			status_valid_q <= 1'b0;
			tag_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			enable_q <= enable_d;
			bkpt_en_q <= bkpt_en_d;
			force_tag_q <= force_tag_d;
			clk_sel_q <= clk_sel_d;
			force_arm_q <= force_arm_d;
			force_pend_q <= force_pend_d;
			status_q <= status_d;
			status_valid_q <= status_valid_d;
			tag_q <= tag_d;
		end
	end

	logic active_q;
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			active_q <= 1'b0;
		else
			active_q <= (state_d == BGDC_ST_ACTIVE);
	end

	assign o_status = status_q;
	assign o_status_valid = status_valid_q;
	assign o_background_active = active_q;
	assign o_tag_opcode = tag_q;
	assign o_link_clock_select = clk_sel_q;

	// Checks
	reset_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_q == BGDC_ST_RESET && i_reset_exit && !i_background_pin
		|=> o_background_active)
		else $error("pin low at reset exit did not enter background");
	reset_normal_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_q == BGDC_ST_RESET && i_reset_exit && i_background_pin
		|=> !o_background_active)
		else $error("pin high at reset exit entered background");
	enable_refuse_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_q == BGDC_ST_RUN && !enable_q |=> state_q != BGDC_ST_ACTIVE)
		else $error("background entered while disabled");
	enable_sticky_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		enable_q |=> enable_q)
		else $error("enable cleared without reset");
	active_report_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_cmd.valid && i_cmd.cmd == BGDC_CMD_READ_STATUS
		|=> o_status[BGDC_BIT_ACTIVE] == ($past(state_q) == BGDC_ST_ACTIVE) && o_status_valid)
		else $error("status active bit wrong");
	bkpt_off_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!bkpt_en_q |-> !force_hit && !tag_hit)
		else $error("breakpoint hit while disabled");
	force_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_q == BGDC_ST_RUN && force_pend_q && i_cpu.insn_boundary && enable_q
		|=> state_q == BGDC_ST_ACTIVE ##0 o_background_active)
		else $error("force breakpoint did not enter background");
	tag_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		state_q == BGDC_ST_RUN && bkpt_en_q && enable_q && i_cpu.queue_end_valid
		&& i_cpu.queue_end_tagged |=> state_q == BGDC_ST_ACTIVE)
		else $error("tagged opcode executed");
	clk_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_cmd.valid && i_cmd.cmd == BGDC_CMD_WRITE_CONTROL
		|=> o_link_clock_select == $past(i_cmd.data[BGDC_BIT_CLK_SEL]))
		else $error("clock select not written");
	low_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_status[2:0] == 3'h0)
		else $error("reserved bits not zero");

	cov_reset_bg: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		state_q == BGDC_ST_RESET ##1 state_q == BGDC_ST_ACTIVE);
	cov_force: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		force_hit ##[1:20] state_q == BGDC_ST_ACTIVE);
	cov_tag: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		tag_hit ##[1:20] state_q == BGDC_ST_ACTIVE);
	cov_go: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		state_q == BGDC_ST_ACTIVE ##1 state_q == BGDC_ST_RUN);
	cov_force_arm: cover property (@(posedge i_sys_clk) disable iff (i_rst)
		force_arm_q && i_reset_exit && !i_background_pin ##1 o_background_active);

endmodule // bgdc_ctrl

// ### tb/bgdc_pod.sv
// Debug pod model on the far side of the single-wire link
`timescale 1ns/1ns
module bgdc_pod
	import bgdc_pkg::*;
(
	// Clock
	input wire logic i_sys_clk,
	// Link side
	output logic o_background_pin,
	output bgdc_cmd_s o_cmd
);
	initial
	begin
		o_background_pin = 1'h1;
		o_cmd = '0;
	end
	// Released pin goes high through the pull-up
	task automatic pin(input logic lvl);
		o_background_pin = lvl;
	endtask
	// Register reached only by serial command strobes
	task automatic send(input bgdc_cmd_e c, input logic [7:0] d);
		o_cmd = '{1'h1, c, d};
		@(posedge i_sys_clk);
		#1;
		// Valid and command cleared so an idle bus never looks valid; stale data inverted
		o_cmd = '{1'h0, BGDC_CMD_NONE, ~d};
		// Idle gap so back-to-back commands never rewrite the strobe at once
		@(posedge i_sys_clk);
		#1;
	endtask
endmodule // bgdc_pod

// ### tb/bgdc_ctrl_bench.sv
// Self-checking bench for the background debug control logic
`timescale 1ns/1ns
module bgdc_ctrl_bench;
	import bgdc_pkg::*;
	logic i_sys_clk, i_rst, i_reset_exit, i_force_reset_cmd, i_background_pin;
	bgdc_cmd_s i_cmd;
	logic [BGDC_AW-1:0] i_match_addr;
	bgdc_cpu_s i_cpu;
	logic [7:0] o_status;
	logic o_status_valid, o_background_active, o_tag_opcode, o_link_clock_select;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [7:0] exp_q[$];
	logic [7:0] d;
	initial
	begin
		i_sys_clk = 1'h0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	bgdc_pod bgdc_pod_inst (.i_sys_clk(i_sys_clk), .o_background_pin(i_background_pin),
		.o_cmd(i_cmd));
	bgdc_ctrl bgdc_ctrl_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_background_pin(i_background_pin), .i_reset_exit(i_reset_exit),
		.i_force_reset_cmd(i_force_reset_cmd), .i_cmd(i_cmd), .i_match_addr(i_match_addr),
		.i_cpu(i_cpu), .o_status(o_status), .o_status_valid(o_status_valid),
		.o_background_active(o_background_active), .o_tag_opcode(o_tag_opcode),
		.o_link_clock_select(o_link_clock_select));
	task automatic print_verdict();
		if (exp_q.size() != 0)
			num_errors++;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic cmp_status(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Sampled on the falling edge so the answer has settled
	always @(negedge i_sys_clk)
		if (o_status_valid !== 1'h0)
		begin
			if (exp_q.size() == 0)
				cmp_status(o_status, 8'hFF);
			else
				cmp_status(o_status, exp_q.pop_front());
		end
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic rd(input logic [7:0] exp);
		exp_q.push_back(exp);
		bgdc_pod_inst.send(BGDC_CMD_READ_STATUS, 8'h00);
		step(1);
	endtask
	task automatic boot(input logic lvl, input logic frc);
		i_rst = 1'h1;
		step(4);
		i_rst = 1'h0;
		i_force_reset_cmd = frc;
		step(1);
		i_force_reset_cmd = 1'h0;
		bgdc_pod_inst.pin(lvl);
		i_reset_exit = 1'h1;
		step(1);
		i_reset_exit = 1'h0;
		bgdc_pod_inst.pin(1'h1);
	endtask
	// Fetch match at random address, then boundary and queue end
	task automatic bkpt(input logic [7:0] ctl, input logic act, input logic tag);
		logic [BGDC_AW-1:0] a;
		a = 16'($urandom);
		bgdc_pod_inst.send(BGDC_CMD_WRITE_CONTROL, ctl);
		i_match_addr = a;
		i_cpu = '{1'h1, a, 1'h0, 1'h0, 1'h0};
		step(1);
		cmp_flag(o_tag_opcode, tag);
		// Tagged queue end only on the tag path, or with breakpoints off
		i_cpu = '{1'h0, ~a, 1'h1, 1'h1, tag | !ctl[BGDC_BIT_BKPT_EN]};
		step(1);
		i_cpu = '0;
		cmp_flag(o_background_active, act);
		bgdc_pod_inst.send(BGDC_CMD_GO, 8'h00);
		step(1);
		$display("breakpoint test with control %h done", ctl);
	endtask
	initial
	begin
		i_reset_exit = 1'h0;
		i_force_reset_cmd = 1'h0;
		i_match_addr = '0;
		i_cpu = '0;
		void'($urandom(86));
		boot(1'h1, 1'h0);
		cmp_flag(o_background_active, 1'h0);
		rd(8'h00);
		bkpt(8'h30, 1'h0, 1'h0);
		rd(8'h30);
		d = 8'($urandom) | 8'h80;
		bgdc_pod_inst.send(BGDC_CMD_WRITE_CONTROL, d);
		rd(d & BGDC_WR_MASK);
		cmp_flag(o_link_clock_select, d[3]);
		bgdc_pod_inst.send(BGDC_CMD_WRITE_CONTROL, 8'h00);
		rd(8'h80);
		$display("register test done");
		bkpt(8'hB0, 1'h1, 1'h0);
		bkpt(8'hA0, 1'h1, 1'h1);
		bkpt(8'h80, 1'h0, 1'h0);
		boot(1'h0, 1'h0);
		cmp_flag(o_background_active, 1'h1);
		rd(8'hC0);
		bgdc_pod_inst.send(BGDC_CMD_GO, 8'h00);
		step(1);
		cmp_flag(o_background_active, 1'h0);
		boot(1'h0, 1'h1);
		cmp_flag(o_background_active, 1'h1);
		$display("background entry test done");
		print_verdict();
	end
endmodule // bgdc_ctrl_bench
